// [rtl/csdae_alu.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// decimal adjust and decrement arithmetic
// ****************************************************************
module csdae_alu (
  input wire logic [7:0] operand, // file byte or accumulator
  input wire logic flag_c, // carry flag in
  input wire logic flag_hc, // low nibble overflow flag in
  output logic [7:0] adj_result, // adjusted accumulator
  output logic adj_carry, // carry after adjust
  output logic [7:0] dec_result, // operand minus one
  output logic [4:0] dec_flags // flags of the decrement
);
  logic [4:0] lo_sum;
  logic lo_carry;
  logic [3:0] hi_add;
  logic [4:0] hi_sum;
  logic [8:0] dec_full;
  logic [4:0] dec_lo;

  always_comb begin
    lo_sum = {1'b0, operand[3:0]};
    if (operand[3:0] > csdae_pkg::BCD_MAX || flag_hc) begin
      lo_sum = lo_sum + {1'b0, csdae_pkg::BCD_FIX};
    end
    // half carry is the carry out of the low nibble fix
    lo_carry = lo_sum[4];
    hi_add = {3'h0, lo_carry};
    if (({1'b0, operand[7:4]} + {4'h0, lo_carry}) > {1'b0, csdae_pkg::BCD_MAX} || flag_c) begin
      hi_add = csdae_pkg::BCD_FIX + {3'h0, lo_carry};
    end
    hi_sum = {1'b0, operand[7:4]} + {1'b0, hi_add};
    adj_result = {hi_sum[3:0], lo_sum[3:0]};
    adj_carry = hi_sum[4] | flag_c;
  end

  always_comb begin
    // subtract one
    // adding all ones of the operand width: carry out set means no borrow
    dec_full = {1'b0, operand} + 9'h0ff;
    dec_lo = {1'b0, operand[3:0]} + 5'h0f;
    dec_result = dec_full[7:0];
    dec_flags = csdae_pkg::FLAGS_RST;
    dec_flags[csdae_pkg::FLG_C] = dec_full[8];
    dec_flags[csdae_pkg::FLG_HC] = dec_lo[4];
    dec_flags[csdae_pkg::FLG_Z] = (dec_full[7:0] == 8'h00);
    dec_flags[csdae_pkg::FLG_OV] = (operand == csdae_pkg::OV_EDGE);
    dec_flags[csdae_pkg::FLG_N] = dec_full[7];
  end
endmodule // csdae_alu
`default_nettype wire

// [rtl/csdae_core.sv]
// Operation
// - word 0110 010a ffff ffff is the greater-than compare and skip
// - greater compare: skip next word when file byte exceeds accumulator, flags untouched
// - word 0110 000a ffff ffff is the less-than compare and skip
// - less compare: skip next word when file byte is below accumulator, flags untouched
// - bank bit 0 picks access bank, bank bit 1 uses bank pointer
// - greater compare uses indexed offset when a=0, extended set on, f<=5Fh
// - compare is one word; one cycle, two when skipping, three over two-word
// - phases decode, read, process, write; each skipped word is four idle phases
// - word 0000 0000 0000 0111 is the decimal adjust instruction
// - decimal adjust turns the accumulator sum into valid packed bcd
// - add 6 to nibbles above 9 or with carry in, high adds half carry
`timescale 1ns/100ps
`default_nettype none
module csdae_core #(
  parameter int BANK_W = csdae_pkg::BANK_W
) (
  input wire logic clk, // 10 MHz core clock
  input wire logic arst_n, // async reset
  input wire logic [5:0] address, // avalon byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte lanes
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon stall
  output logic [3:0] q_phase, // one-hot q1..q4
  output logic skipping // discarded word in progress
);
  localparam int ADDR_W = BANK_W + 8;
  localparam int MEM_DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // declarations
  // ****************************************************************
  csdae_pkg::csdae_state_t state;
  csdae_pkg::csdae_op_t op_kind, next_op;
  logic [7:0] mem [MEM_DEPTH];
  logic [15:0] instr_word;
  logic [7:0] acc, operand, file_f, adj_result, dec_result;
  logic [4:0] flags, dec_flags;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] index_base, mem_addr, eff_addr, next_addr;
  logic [1:0] cycles;
  logic [31:0] next_readdata, wmerge;
  logic ctrl_ext, two_word_next, dest_file, illegal, skip_hit, skipped_last;
  logic bus_take, wr_fire, start, exec_q1, exec_q4, adj_carry;

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  // request taken only while idle, so registers never move between
  // the sampling of read data and its hand-over
  assign bus_take = (read | write) & waitrequest & (state == csdae_pkg::ST_IDLE);
  assign wr_fire = write & ~waitrequest;
  assign start = wr_fire && (address == csdae_pkg::REG_INSTR);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = byteenable[i] ? writedata[i*8 +: 8] : 8'h00;
    end
  end

  always_comb begin
    next_readdata = csdae_pkg::READ_UNMAPPED;
    if (address == csdae_pkg::REG_CTRL) begin
      next_readdata[csdae_pkg::CTRL_EXT_BIT] = ctrl_ext;
    end else if (address == csdae_pkg::REG_INSTR) begin
      next_readdata[15:0] = instr_word;
      next_readdata[csdae_pkg::INSTR_TWO_WORD_BIT] = two_word_next;
    end else if (address == csdae_pkg::REG_ACC) begin
      next_readdata[7:0] = acc;
    end else if (address == csdae_pkg::REG_FLAGS) begin
      next_readdata[csdae_pkg::FLAGS_W-1:0] = flags;
    end else if (address == csdae_pkg::REG_BANK) begin
      next_readdata[BANK_W-1:0] = bank;
    end else if (address == csdae_pkg::REG_INDEX) begin
      next_readdata[ADDR_W-1:0] = index_base;
    end else if (address == csdae_pkg::REG_MEM_ADDR) begin
      next_readdata[ADDR_W-1:0] = mem_addr;
    end else if (address == csdae_pkg::REG_MEM_DATA) begin
      next_readdata[7:0] = mem[mem_addr];
    end else if (address == csdae_pkg::REG_EXEC) begin
      next_readdata[csdae_pkg::EXEC_BUSY_BIT] = (state != csdae_pkg::ST_IDLE);
      next_readdata[csdae_pkg::EXEC_SKIP_BIT] = skipped_last;
      next_readdata[csdae_pkg::EXEC_ILLEGAL_BIT] = illegal;
      next_readdata[csdae_pkg::EXEC_CYC_LSB +: csdae_pkg::CYC_W] = cycles;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= csdae_pkg::READ_UNMAPPED;
    end else begin
      waitrequest <= ~bus_take;
      if (bus_take) begin
        readdata <= next_readdata;
      end
    end
  end

  // byte lanes: outside the memory window, a lane that is not enabled writes zero into its field
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ext <= 1'b0;
      instr_word <= csdae_pkg::INSTR_RST;
      two_word_next <= 1'b0;
      bank <= '0;
      index_base <= '0;
      mem_addr <= '0;
    end else if (wr_fire) begin
      if (address == csdae_pkg::REG_CTRL) begin
        ctrl_ext <= wmerge[csdae_pkg::CTRL_EXT_BIT];
      end else if (address == csdae_pkg::REG_INSTR) begin
        instr_word <= wmerge[15:0];
        two_word_next <= wmerge[csdae_pkg::INSTR_TWO_WORD_BIT];
      end else if (address == csdae_pkg::REG_BANK) begin
        bank <= wmerge[BANK_W-1:0];
      end else if (address == csdae_pkg::REG_INDEX) begin
        index_base <= wmerge[ADDR_W-1:0];
      end else if (address == csdae_pkg::REG_MEM_ADDR) begin
        mem_addr <= wmerge[ADDR_W-1:0];
      end
    end
  end

  // ****************************************************************
  // q phase sequencer
  // ****************************************************************
  assign exec_q1 = (state == csdae_pkg::ST_EXEC) && (q_phase == csdae_pkg::Q1);
  assign exec_q4 = (state == csdae_pkg::ST_EXEC) && (q_phase == csdae_pkg::Q4);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= csdae_pkg::ST_IDLE;
      q_phase <= csdae_pkg::Q_IDLE;
      cycles <= csdae_pkg::CYC_ZERO;
      skipping <= 1'b0;
      skipped_last <= 1'b0;
    end else begin
      case (state)
        csdae_pkg::ST_IDLE: begin
          if (start) begin
            state <= csdae_pkg::ST_EXEC;
            q_phase <= csdae_pkg::Q1;
            cycles <= csdae_pkg::CYC_ONE;
            skipped_last <= 1'b0;
          end
        end
        csdae_pkg::ST_EXEC: begin
          q_phase <= {q_phase[2:0], q_phase[3]};
          if (q_phase == csdae_pkg::Q4) begin
            if (skip_hit) begin
              state <= csdae_pkg::ST_SKIP1;
              cycles <= cycles + csdae_pkg::CYC_ONE;
              skipping <= 1'b1;
              skipped_last <= 1'b1;
            end else begin
              state <= csdae_pkg::ST_IDLE;
              q_phase <= csdae_pkg::Q_IDLE;
            end
          end
        end
        csdae_pkg::ST_SKIP1: begin
          q_phase <= {q_phase[2:0], q_phase[3]};
          if (q_phase == csdae_pkg::Q4) begin
            // third cycle over a two-word instruction
            if (two_word_next) begin
              state <= csdae_pkg::ST_SKIP2;
              cycles <= cycles + csdae_pkg::CYC_ONE;
            end else begin
              state <= csdae_pkg::ST_IDLE;
              q_phase <= csdae_pkg::Q_IDLE;
              skipping <= 1'b0;
            end
          end
        end
        csdae_pkg::ST_SKIP2: begin
          q_phase <= {q_phase[2:0], q_phase[3]};
          if (q_phase == csdae_pkg::Q4) begin
            state <= csdae_pkg::ST_IDLE;
            q_phase <= csdae_pkg::Q_IDLE;
            skipping <= 1'b0;
          end
        end
        default: begin
          state <= csdae_pkg::ST_IDLE;
          q_phase <= csdae_pkg::Q_IDLE;
          skipping <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // q1 decode and address formation
  // ****************************************************************
  assign file_f = instr_word[7:0];

  always_comb begin
    next_op = csdae_pkg::OP_NONE;
    if (instr_word[15:9] == csdae_pkg::GT_PFX) begin
      next_op = csdae_pkg::OP_GT;
    end else if (instr_word[15:9] == csdae_pkg::LT_PFX) begin
      next_op = csdae_pkg::OP_LT;
    end else if (instr_word == csdae_pkg::ADJ_WORD) begin
      next_op = csdae_pkg::OP_ADJ;
    end else if (instr_word[15:10] == csdae_pkg::DEC_PFX) begin
      next_op = csdae_pkg::OP_DEC;
    end
    if (ctrl_ext && !instr_word[csdae_pkg::A_BIT] && file_f <= csdae_pkg::INDEXED_MAX &&
        (next_op == csdae_pkg::OP_GT || next_op == csdae_pkg::OP_DEC)) begin
      next_addr = index_base + {{BANK_W{1'b0}}, file_f};
    end else if (instr_word[csdae_pkg::A_BIT]) begin
      next_addr = {bank, file_f};
    end else if (file_f < csdae_pkg::ACCESS_SPLIT) begin
      next_addr = {{BANK_W{1'b0}}, file_f};
    end else begin
      next_addr = {{BANK_W{1'b1}}, file_f};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_kind <= csdae_pkg::OP_NONE;
      eff_addr <= '0;
      dest_file <= 1'b0;
      illegal <= 1'b0;
    end else if (exec_q1) begin
      op_kind <= next_op;
      eff_addr <= next_addr;
      dest_file <= instr_word[csdae_pkg::D_BIT];
      illegal <= (next_op == csdae_pkg::OP_NONE);
    end
  end

  // ****************************************************************
  // q2 read, q3 process
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operand <= 8'h00;
    end else if (state == csdae_pkg::ST_EXEC && q_phase == csdae_pkg::Q2) begin
      operand <= (op_kind == csdae_pkg::OP_ADJ) ? acc : mem[eff_addr];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_hit <= 1'b0;
    end else if (exec_q1) begin
      skip_hit <= 1'b0;
    end else if (state == csdae_pkg::ST_EXEC && q_phase == csdae_pkg::Q3) begin
      skip_hit <= (op_kind == csdae_pkg::OP_GT && operand > acc) ||
                  (op_kind == csdae_pkg::OP_LT && operand < acc);
    end
  end

  csdae_alu u_alu (
    .operand(operand),
    .flag_c(flags[csdae_pkg::FLG_C]),
    .flag_hc(flags[csdae_pkg::FLG_HC]),
    .adj_result(adj_result),
    .adj_carry(adj_carry),
    .dec_result(dec_result),
    .dec_flags(dec_flags)
  );

  // ****************************************************************
  // q4 write back
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= csdae_pkg::ACC_RST;
    end else if (wr_fire && address == csdae_pkg::REG_ACC) begin
      acc <= wmerge[7:0];
    end else if (exec_q4 && op_kind == csdae_pkg::OP_ADJ) begin
      acc <= adj_result;
    end else if (exec_q4 && op_kind == csdae_pkg::OP_DEC && !dest_file) begin
      acc <= dec_result;
    end
  end

  // compares never reach this process, so their flags stay put
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= csdae_pkg::FLAGS_RST;
    end else if (wr_fire && address == csdae_pkg::REG_FLAGS) begin
      flags <= wmerge[csdae_pkg::FLAGS_W-1:0];
    end else if (exec_q4 && op_kind == csdae_pkg::OP_ADJ) begin
      flags[csdae_pkg::FLG_C] <= adj_carry;
    end else if (exec_q4 && op_kind == csdae_pkg::OP_DEC) begin
      flags <= dec_flags;
    end
  end

  // data memory has no reset; software loads it through the window
  always_ff @(posedge clk) begin
    if (wr_fire && address == csdae_pkg::REG_MEM_DATA && byteenable[0]) begin
      mem[mem_addr] <= writedata[7:0];
    end else if (exec_q4 && op_kind == csdae_pkg::OP_DEC && dest_file) begin
      mem[eff_addr] <= dec_result;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_exec_q1;
    state == csdae_pkg::ST_EXEC && q_phase == csdae_pkg::Q1;
  endsequence
  sequence s_skip_word;
    (state == csdae_pkg::ST_SKIP1) [*4];
  endsequence

  chk_gt_decode: assert property (s_exec_q1 ##0 instr_word[15:9] == 7'h32 |=> op_kind == csdae_pkg::OP_GT)
    else $error("greater compare not decoded");
  chk_lt_decode: assert property (s_exec_q1 ##0 instr_word[15:9] == 7'h30 |=> op_kind == csdae_pkg::OP_LT)
    else $error("less compare not decoded");
  chk_adj_decode: assert property (s_exec_q1 ##0 instr_word == 16'h0007 |=> op_kind == csdae_pkg::OP_ADJ)
    else $error("decimal adjust not decoded");
  chk_gt_skip: assert property (state == csdae_pkg::ST_EXEC && q_phase == csdae_pkg::Q3 && op_kind == csdae_pkg::OP_GT
    |=> skip_hit == (operand > acc))
    else $error("greater compare skip wrong");
  chk_lt_skip: assert property (state == csdae_pkg::ST_EXEC && q_phase == csdae_pkg::Q3 && op_kind == csdae_pkg::OP_LT
    |=> skip_hit == (operand < acc))
    else $error("less compare skip wrong");
  chk_cmp_flags_kept: assert property (s_exec_q1 ##0 (next_op == csdae_pkg::OP_GT || next_op == csdae_pkg::OP_LT)
    |=> $stable(flags) [*4])
    else $error("compare changed flags");
  chk_bank_select: assert property (s_exec_q1 ##0 instr_word[8] |=> eff_addr == {$past(bank), $past(file_f)})
    else $error("bank pointer not used");
  chk_index_mode: assert property (s_exec_q1 ##0 ctrl_ext && next_op == csdae_pkg::OP_GT && !instr_word[8] &&
    file_f <= 8'h5f |=> eff_addr == $past(index_base) + {{BANK_W{1'b0}}, $past(file_f)})
    else $error("indexed offset address wrong");
  chk_two_word_skip: assert property (exec_q4 && skip_hit && two_word_next
    |=> s_skip_word ##1 (state == csdae_pkg::ST_SKIP2) [*4] ##1 state == csdae_pkg::ST_IDLE && cycles == 2'h3)
    else $error("two-word skip length wrong");
  chk_no_skip_len: assert property (exec_q4 && !skip_hit |=> state == csdae_pkg::ST_IDLE && cycles == 2'h1)
    else $error("plain compare length wrong");
  chk_skip_idle: assert property ((state == csdae_pkg::ST_SKIP1 || state == csdae_pkg::ST_SKIP2)
    |=> $stable(acc) && $stable(flags))
    else $error("skipped word did work");
  chk_adj_write: assert property (exec_q4 && op_kind == csdae_pkg::OP_ADJ |=>
    (($past(operand[3:0]) > 4'h9 || $past(flags[csdae_pkg::FLG_HC])) ? acc[3:0] == 4'($past(operand[3:0]) + 4'h6)
    : acc[3:0] == $past(operand[3:0])) && (flags[csdae_pkg::FLG_C] || !$past(flags[csdae_pkg::FLG_C])))
    else $error("decimal adjust result wrong");
  chk_dec_acc: assert property (exec_q4 && op_kind == csdae_pkg::OP_DEC && !dest_file
    |=> acc == 8'($past(operand) - 8'h01))
    else $error("decrement result wrong");
endmodule // csdae_core
`default_nettype wire

// [rtl/csdae_pkg.sv]
`default_nettype none
// ****************************************************************
// shared constants for the compare/skip and decimal adjust executor
// ****************************************************************
package csdae_pkg;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int BUS_W = 32;
  localparam int BUS_AW = 6;

  // register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_INSTR = 6'h04;
  localparam logic [5:0] REG_ACC = 6'h08;
  localparam logic [5:0] REG_FLAGS = 6'h0c;
  localparam logic [5:0] REG_BANK = 6'h10;
  localparam logic [5:0] REG_INDEX = 6'h14;
  localparam logic [5:0] REG_MEM_ADDR = 6'h18;
  localparam logic [5:0] REG_MEM_DATA = 6'h1c;
  localparam logic [5:0] REG_EXEC = 6'h20;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int INSTR_TWO_WORD_BIT = 16;
  localparam int FLG_C = 0;
  localparam int FLG_HC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int FLAGS_W = 5;
  localparam int EXEC_BUSY_BIT = 0;
  localparam int EXEC_SKIP_BIT = 1;
  localparam int EXEC_ILLEGAL_BIT = 2;
  localparam int EXEC_CYC_LSB = 4;
  localparam int CYC_W = 2;
  localparam int A_BIT = 8;
  localparam int D_BIT = 9;

  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [1:0] CYC_ZERO = 2'h0;
  localparam logic [1:0] CYC_ONE = 2'h1;

  // encodings
  localparam logic [6:0] GT_PFX = 7'h32;
  localparam logic [6:0] LT_PFX = 7'h30;
  localparam logic [15:0] ADJ_WORD = 16'h0007;
  localparam logic [5:0] DEC_PFX = 6'h01;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;
  localparam logic [7:0] OV_EDGE = 8'h80;

  // one-hot q phases
  localparam logic [3:0] Q_IDLE = 4'h0;
  localparam logic [3:0] Q1 = 4'h1;
  localparam logic [3:0] Q2 = 4'h2;
  localparam logic [3:0] Q3 = 4'h4;
  localparam logic [3:0] Q4 = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_SKIP1 = 4'h4,
    ST_SKIP2 = 4'h8
  } csdae_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_GT = 3'h1,
    OP_LT = 3'h2,
    OP_ADJ = 3'h3,
    OP_DEC = 3'h4
  } csdae_op_t;
endpackage
`default_nettype wire

// [testbench/compare_skip_decimal_adjust_exec_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module compare_skip_decimal_adjust_exec_bench;
  logic clk;
  logic arst_n;
  logic read;
  logic write;
  logic waitrequest;
  logic skipping;
  logic [5:0] address;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic [3:0] byteenable;
  logic [3:0] q_phase;
  int failures;
  int n_compared;
  int n_skip;
  int n_q4;
  logic [7:0] adj_tab [4][4];

  csdae_core dut (
    .clk(clk),
    .arst_n(arst_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .q_phase(q_phase),
    .skipping(skipping)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts discarded phases and executed q4 phases per instruction
  always @(posedge clk) begin
    if (skipping === 1'b1) n_skip++;
    if (q_phase === csdae_pkg::Q4 && skipping === 1'b0) n_q4++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic close_out;
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; an idle cycle always precedes the request
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 100) begin
      failures++;
      close_out();
    end else begin
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
    end
  endtask

  task automatic mem(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, csdae_pkg::REG_MEM_ADDR, {20'h0, a});
    bus(1'b1, csdae_pkg::REG_MEM_DATA, {24'h0, d});
  endtask

  task automatic run(input logic [16:0] w, input logic [1:0] cyc);
    n_skip = 0;
    n_q4 = 0;
    bus(1'b1, csdae_pkg::REG_INSTR, {15'h0, w});
    bus(1'b0, csdae_pkg::REG_EXEC, 32'h0);
    check({30'h0, rd[5:4]}, {30'h0, cyc});
    check({31'h0, rd[1]}, {31'h0, cyc != 2'h1});
    check(32'(n_skip), 32'((int'(cyc) - 1) * 4));
    check(32'(n_q4), 32'h1);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    failures = 0;
    n_compared = 0;
    n_skip = 0;
    n_q4 = 0;
    // acc in, flags in, acc out, flags out
    adj_tab = '{'{8'ha5, 8'h00, 8'h05, 8'h01}, '{8'hce, 8'h00, 8'h34, 8'h01},
                '{8'h12, 8'h02, 8'h18, 8'h02}, '{8'h20, 8'h01, 8'h80, 8'h01}};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, csdae_pkg::REG_ACC, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    check(rd, csdae_pkg::READ_UNMAPPED);
    bus(1'b1, csdae_pkg::REG_BANK, 32'h3);
    mem(12'h310, 8'h50);
    mem(12'h311, 8'h30);
    mem(12'h010, 8'h20);
    mem(12'hf70, 8'h40);
    mem(12'h205, 8'h60);
    mem(12'h005, 8'h10);
    bus(1'b1, csdae_pkg::REG_ACC, 32'h30);
    bus(1'b1, csdae_pkg::REG_FLAGS, 32'h1f);
    run({1'b0, csdae_pkg::GT_PFX, 1'b1, 8'h10}, 2'h2);
    run({1'b1, csdae_pkg::GT_PFX, 1'b0, 8'h10}, 2'h1);
    run({1'b0, csdae_pkg::GT_PFX, 1'b1, 8'h11}, 2'h1);
    run({1'b1, csdae_pkg::LT_PFX, 1'b0, 8'h10}, 2'h3);
    run({1'b0, csdae_pkg::LT_PFX, 1'b1, 8'h11}, 2'h1);
    run({1'b1, csdae_pkg::GT_PFX, 1'b0, 8'h70}, 2'h3);
    bus(1'b1, csdae_pkg::REG_CTRL, 32'h1);
    bus(1'b1, csdae_pkg::REG_INDEX, 32'h200);
    run({1'b0, csdae_pkg::GT_PFX, 1'b0, 8'h05}, 2'h2);
    run({1'b0, csdae_pkg::LT_PFX, 1'b0, 8'h05}, 2'h2);
    run({1'b0, 16'hfe05}, 2'h1);
    check({31'h0, rd[2]}, 32'h1);
    bus(1'b0, csdae_pkg::REG_FLAGS, 32'h0);
    check(rd, 32'h1f);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, csdae_pkg::REG_ACC, {24'h0, adj_tab[k][0]});
      bus(1'b1, csdae_pkg::REG_FLAGS, {24'h0, adj_tab[k][1]});
      run({1'b0, csdae_pkg::ADJ_WORD}, 2'h1);
      bus(1'b0, csdae_pkg::REG_ACC, 32'h0);
      check(rd, {24'h0, adj_tab[k][2]});
      bus(1'b0, csdae_pkg::REG_FLAGS, 32'h0);
      check(rd, {24'h0, adj_tab[k][3]});
    end
    mem(12'h320, 8'h01);
    mem(12'h321, 8'h80);
    bus(1'b1, csdae_pkg::REG_FLAGS, 32'h0);
    run({1'b0, csdae_pkg::DEC_PFX, 1'b1, 1'b1, 8'h20}, 2'h1);
    bus(1'b1, csdae_pkg::REG_MEM_ADDR, 32'h320);
    bus(1'b0, csdae_pkg::REG_MEM_DATA, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, csdae_pkg::REG_FLAGS, 32'h0);
    check(rd, 32'h07);
    run({1'b0, csdae_pkg::DEC_PFX, 1'b0, 1'b1, 8'h21}, 2'h1);
    bus(1'b0, csdae_pkg::REG_ACC, 32'h0);
    check(rd, 32'h7f);
    bus(1'b0, csdae_pkg::REG_FLAGS, 32'h0);
    check(rd, 32'h09);
    close_out();
  end
endmodule // compare_skip_decimal_adjust_exec_bench
`default_nettype wire
